// file: supervisor_pkg.sv
// Shared constants and types for the start-up fault and power mode supervisor
package supervisor_pkg;

   // ==========================================
   // Clock and timing
   // ==========================================
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned RATE_10M_HZ     = 10_000_000;
   localparam int unsigned RATE_1M_HZ      = 1_000_000;
   localparam int unsigned RATE_100K_HZ    = 100_000;
   localparam int unsigned RATE_10K_HZ     = 10_000;
   localparam int unsigned DIV_10M         = CLK_HZ / RATE_10M_HZ;
   localparam int unsigned DIV_1M          = CLK_HZ / RATE_1M_HZ;
   localparam int unsigned DIV_100K        = CLK_HZ / RATE_100K_HZ;
   localparam int unsigned DIV_10K         = CLK_HZ / RATE_10K_HZ;
   localparam int unsigned DIV_W           = 14;
   localparam int unsigned DETECT_TIMER_W  = 12;
   localparam int unsigned RATE_STEPS      = 4;

   // ==========================================
   // Speed input, profile and start-up method encodings
   // ==========================================
   localparam logic [1:0] SPEED_ANALOG     = 2'h0;
   localparam logic [1:0] SPEED_DUTY       = 2'h1;
   localparam logic [1:0] SPEED_SERIAL     = 2'h2;
   localparam logic [1:0] SPEED_FREQ       = 2'h3;
   localparam logic [1:0] PROFILE_DEFAULT  = 2'h0;
   localparam logic [1:0] STARTUP_POS_DET  = 2'h2;

   // Speed commands are 16-bit fractions, full scale FFFF for analog/duty
   localparam int unsigned SPEED_W         = 16;
   localparam logic [15:0] PCT_1           = 16'h028F;
   localparam logic [15:0] PCT_5           = 16'h0CCC;
   localparam logic [15:0] SERIAL_FS       = 16'h7FFF;
   localparam logic [15:0] FREQ_MIN_HZ     = 16'h0003;

   // Sleep detection times and retry unit (cycles), shortened by top parameters
   localparam int unsigned SLEEP_DET_DEF   = 100_000;
   localparam int unsigned WAKE_DET_DEF    = 10_000;
   localparam int unsigned RETRY_UNIT_DEF  = 1_000_000;
   localparam int unsigned CNT_W           = 24;

   // ==========================================
   // Types
   // ==========================================
   typedef enum logic [1:0] {POWER_RUN, POWER_STANDBY, POWER_SLEEP} power_type;

   typedef struct packed {
      logic rampup_timeout_fault;
      logic rampdown_timeout_fault;
      logic pulse_rate_fault;
      logic meas_rl_fault;
      logic meas_backemf_fault;
   } fault_type;

   typedef struct packed {
      logic [1:0]  speed_mode;
      logic [1:0]  profile_config;
      logic [15:0] duty_hysteresis;
      logic [15:0] input_max_freq;
   } speed_cfg_type;

endpackage

// file: rate_stepper.sv
// Detection timer with four stepped clock rates
`timescale 1ns/1ps
module rate_stepper
   import supervisor_pkg::*;
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Control
   input  wire logic start_in,
   input  wire logic done_in,
   // Result
   output logic      overflow_out,
   output logic      exhausted_out,
   output logic      busy_out
);

   logic [1:0]                step_ff;
   logic [DIV_W-1:0]          div_ff;
   logic [DETECT_TIMER_W-1:0] timer_ff;
   logic                      tick;
   logic [DIV_W-1:0]          div_top;

   // Divider reload per step
   always_comb
   begin
      unique case (step_ff)
         2'h0: div_top = DIV_W'(DIV_10M - 1);
         2'h1: div_top = DIV_W'(DIV_1M - 1);
         2'h2: div_top = DIV_W'(DIV_100K - 1);
         2'h3: div_top = DIV_W'(DIV_10K - 1);
      endcase
   end

   assign tick = busy_out && (div_ff == div_top);

   // Prescaler gives one-cycle tick at the current rate
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         div_ff <= '0;
      else if (start_in || tick || !busy_out)
         div_ff <= '0;
      else
         div_ff <= div_ff + 1'b1;
   end

   // 12-bit timer; wrap marks overflow and steps to next slower rate
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         busy_out      <= 1'b0;
         step_ff       <= '0;
         timer_ff      <= '0;
         overflow_out  <= 1'b0;
         exhausted_out <= 1'b0;
      end
      else
      begin
         overflow_out  <= 1'b0;
         exhausted_out <= 1'b0;
         if (start_in)
         begin
            busy_out <= 1'b1;
            step_ff  <= '0;     // fastest rate first
            timer_ff <= '0;
         end
         else if (busy_out && done_in)
            busy_out <= 1'b0;
         else if (tick)
         begin
            timer_ff <= timer_ff + 1'b1;
            if (&timer_ff)
            begin
               overflow_out <= 1'b1;
               if (step_ff == 2'(RATE_STEPS - 1))
               begin
                  exhausted_out <= 1'b1;   // all four rates failed
                  busy_out      <= 1'b0;
               end
               else
                  step_ff <= step_ff + 1'b1;
            end
         end
      end
   end

endmodule

// file: standby_threshold.sv
// Standby entry and exit thresholds per speed input mode
`timescale 1ns/1ps
module standby_threshold
   import supervisor_pkg::*;
(
   // Configuration
   input  speed_cfg_type     cfg_in,
   // Thresholds
   output logic [15:0]       enter_out,
   output logic [15:0]       exit_out
);

   logic [15:0] hys_max;
   logic [31:0] prod;

   always_comb
   begin
      hys_max = (cfg_in.duty_hysteresis > PCT_1) ? cfg_in.duty_hysteresis : PCT_1;
      prod    = 32'h0;
      unique case (cfg_in.speed_mode)
         SPEED_ANALOG:
         begin
            enter_out = PCT_1;
            exit_out  = PCT_5;
         end
         SPEED_DUTY:
         begin
            enter_out = (cfg_in.profile_config == PROFILE_DEFAULT) ? hys_max : 16'h0000;
            exit_out  = enter_out;
         end
         SPEED_SERIAL:
         begin
            prod      = hys_max * SERIAL_FS;
            enter_out = (cfg_in.profile_config == PROFILE_DEFAULT) ? prod[31:16] : 16'h0000;
            exit_out  = enter_out;
         end
         SPEED_FREQ:
         begin
            prod      = hys_max * cfg_in.input_max_freq;
            enter_out = prod[31:16];
            if (enter_out < FREQ_MIN_HZ || cfg_in.profile_config != PROFILE_DEFAULT)
               enter_out = FREQ_MIN_HZ;       // floor, else just under 3 Hz by strict compare
            exit_out  = enter_out;
         end
      endcase
   end

endmodule

// file: startup_supervisor.sv
// Start-up fault and power mode supervisor top level
`timescale 1ns/1ps
module startup_supervisor
   import supervisor_pkg::*;
#(
   parameter int unsigned SLEEP_DET_CYC  = SLEEP_DET_DEF,
   parameter int unsigned WAKE_DET_CYC   = WAKE_DET_DEF,
   parameter int unsigned RETRY_UNIT_CYC = RETRY_UNIT_DEF
)
(
   // Clock and reset
   input  wire logic          MCLK_IN,
   input  wire logic          RST_B_IN,
   // Configuration
   input  wire logic [1:0]    STARTUP_METHOD_IN,
   input  wire logic          DETECT_TIMEOUT_FAULT_ENABLE_IN,
   input  wire logic          PULSE_RATE_FAULT_ENABLE_IN,
   input  wire logic          IDLE_STATE_SELECT_IN,
   input  wire logic [3:0]    LOCK_RETRY_TIME_IN,
   input  wire speed_cfg_type SPEED_CFG_IN,
   input  wire logic [15:0]   STATIONARY_DETECT_THRESHOLD_IN,
   // Start-up detection events
   input  wire logic          STARTUP_REQ_IN,
   input  wire logic          RAMPUP_START_IN,
   input  wire logic          RAMPDOWN_START_IN,
   input  wire logic          CURRENT_AT_THRESHOLD_IN,
   input  wire logic          CURRENT_ZERO_IN,
   input  wire logic          DETECT_PULSE_IN,
   // Parameter measurement events
   input  wire logic          MEAS_RL_ACTIVE_IN,
   input  wire logic          MEAS_BACKEMF_VALID_IN,
   input  wire logic [15:0]   MEAS_BACKEMF_IN,
   // Speed command and pins
   input  wire logic [15:0]   SPEED_COMMAND_IN,
   input  wire logic          SPEED_PIN_HIGH_IN,
   input  wire logic          SPEED_PIN_LOW_IN,
   input  wire logic          OUTPUT_DISABLE_PIN_IN,
   input  wire logic          LATCHED_FAULT_IN,
   input  wire logic          FAULT_CONDITION_ACTIVE_IN,
   input  wire logic          CLEAR_FAULT_BIT_IN,
   // Status and control outputs
   output fault_type          FAULTS_OUT,
   output power_type          POWER_STATE_OUT,
   output logic               SWITCHES_HIZ_OUT,
   output logic               SUPPLIES_ENABLE_OUT,
   output logic               STARTUP_ABORT_OUT,
   output logic               STARTUP_RETRY_OUT,
   output logic               PARTIAL_SHUTDOWN_OUT
);

   // ==========================================
   // Detection timers
   // ==========================================
   logic      pos_mode;
   logic      up_exh;
   logic      dn_exh;
   logic      dn_busy;
   logic      rl_exh;
   logic      rl_active_ff;
   logic      rl_start;
   logic      pulse_fault_evt;
   logic      detect_fault_evt;

   assign pos_mode = (STARTUP_METHOD_IN == STARTUP_POS_DET);

   rate_stepper u_rampup (
      .clk_in        (MCLK_IN),
      .rst_b_in      (RST_B_IN),
      .start_in      (RAMPUP_START_IN && pos_mode),
      .done_in       (CURRENT_AT_THRESHOLD_IN),
      .overflow_out  (),
      .exhausted_out (up_exh),
      .busy_out      ()
   );

   rate_stepper u_rampdown (
      .clk_in        (MCLK_IN),
      .rst_b_in      (RST_B_IN),
      .start_in      (RAMPDOWN_START_IN && pos_mode),
      .done_in       (CURRENT_ZERO_IN),
      .overflow_out  (),
      .exhausted_out (dn_exh),
      .busy_out      (dn_busy)
   );

   // Measurement ramp shares the detection timer behaviour
   assign rl_start = MEAS_RL_ACTIVE_IN && !rl_active_ff;

   rate_stepper u_meas_rl (
      .clk_in        (MCLK_IN),
      .rst_b_in      (RST_B_IN),
      .start_in      (rl_start),
      .done_in       (CURRENT_AT_THRESHOLD_IN || !MEAS_RL_ACTIVE_IN),
      .overflow_out  (),
      .exhausted_out (rl_exh),
      .busy_out      ()
   );

   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         rl_active_ff <= 1'b0;
      else
         rl_active_ff <= MEAS_RL_ACTIVE_IN;
   end

   // New pulse while previous decay still being timed
   assign pulse_fault_evt  = PULSE_RATE_FAULT_ENABLE_IN && DETECT_PULSE_IN && dn_busy;
   assign detect_fault_evt = (DETECT_TIMEOUT_FAULT_ENABLE_IN && (up_exh || dn_exh)) || pulse_fault_evt;

   // ==========================================
   // Sticky fault flags; a new event wins over clear
   // ==========================================
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         FAULTS_OUT <= '0;
      else
      begin
         if (CLEAR_FAULT_BIT_IN)
            FAULTS_OUT <= '0;
         if (DETECT_TIMEOUT_FAULT_ENABLE_IN && up_exh)
            FAULTS_OUT.rampup_timeout_fault <= 1'b1;
         if (DETECT_TIMEOUT_FAULT_ENABLE_IN && dn_exh)
            FAULTS_OUT.rampdown_timeout_fault <= 1'b1;
         if (pulse_fault_evt)
            FAULTS_OUT.pulse_rate_fault <= 1'b1;
         if (rl_exh)
            FAULTS_OUT.meas_rl_fault <= 1'b1;
         if (MEAS_BACKEMF_VALID_IN && MEAS_BACKEMF_IN < STATIONARY_DETECT_THRESHOLD_IN)
            FAULTS_OUT.meas_backemf_fault <= 1'b1;
      end
   end

   // ==========================================
   // Abort and automatic retry
   // ==========================================
   logic [CNT_W-1:0] unit_ff;
   logic [3:0]       units_ff;
   logic             retry_wait_ff;

   // Retry interval is lock retry setting plus one units; zero setting still waits one unit
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         retry_wait_ff     <= 1'b0;
         unit_ff           <= '0;
         units_ff          <= '0;
         STARTUP_ABORT_OUT <= 1'b0;
         STARTUP_RETRY_OUT <= 1'b0;
      end
      else
      begin
         STARTUP_RETRY_OUT <= 1'b0;
         if (detect_fault_evt)
         begin
            retry_wait_ff     <= 1'b1;
            STARTUP_ABORT_OUT <= 1'b1;
            unit_ff           <= '0;
            units_ff          <= '0;
         end
         else if (retry_wait_ff)
         begin
            if (unit_ff == CNT_W'(RETRY_UNIT_CYC - 1))
            begin
               unit_ff <= '0;
               if (units_ff == LOCK_RETRY_TIME_IN)
               begin
                  retry_wait_ff     <= 1'b0;
                  STARTUP_ABORT_OUT <= 1'b0;
                  STARTUP_RETRY_OUT <= 1'b1;
               end
               else
                  units_ff <= units_ff + 1'b1;
            end
            else
               unit_ff <= unit_ff + 1'b1;
         end
      end
   end

   // ==========================================
   // Latched fault and clear
   // ==========================================
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         PARTIAL_SHUTDOWN_OUT <= 1'b0;
      else if (LATCHED_FAULT_IN)
         PARTIAL_SHUTDOWN_OUT <= 1'b1;
      else if (CLEAR_FAULT_BIT_IN && !FAULT_CONDITION_ACTIVE_IN)
         PARTIAL_SHUTDOWN_OUT <= 1'b0;
   end

   // ==========================================
   // Standby and sleep sequencing
   // ==========================================
   logic [15:0]      enter_thr;
   logic [15:0]      exit_thr;
   logic [CNT_W-1:0] det_ff;
   power_type        nxt_power;
   logic             det_clear;

   standby_threshold u_thr (
      .cfg_in    (SPEED_CFG_IN),
      .enter_out (enter_thr),
      .exit_out  (exit_thr)
   );

   // Dwell counter for pin level detection; resets when the watched level breaks
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         det_ff <= '0;
      else if (det_clear)
         det_ff <= '0;
      else if (det_ff != {CNT_W{1'b1}})
         det_ff <= det_ff + 1'b1;
   end

   always_comb
   begin
      nxt_power = POWER_STATE_OUT;
      det_clear = 1'b1;
      unique case (POWER_STATE_OUT)
         POWER_RUN:
            if (IDLE_STATE_SELECT_IN)
            begin
               det_clear = !SPEED_PIN_LOW_IN;
               if (SPEED_PIN_LOW_IN && det_ff >= CNT_W'(SLEEP_DET_CYC - 1))
                  nxt_power = POWER_SLEEP;
            end
            else if (SPEED_COMMAND_IN < enter_thr)
               nxt_power = POWER_STANDBY;
         POWER_STANDBY:
            if (SPEED_COMMAND_IN > exit_thr)
               nxt_power = POWER_RUN;
         POWER_SLEEP:
         begin
            det_clear = !SPEED_PIN_HIGH_IN;
            if (SPEED_PIN_HIGH_IN && det_ff >= CNT_W'(WAKE_DET_CYC - 1))
               nxt_power = POWER_RUN;   // wake also in serial mode
         end
         default:
            nxt_power = POWER_RUN;
      endcase
   end

   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         POWER_STATE_OUT <= POWER_RUN;
      else
         POWER_STATE_OUT <= nxt_power;
   end

   // Supplies drop only in sleep; standby keeps them for fast restart
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         SUPPLIES_ENABLE_OUT <= 1'b1;
      else
         SUPPLIES_ENABLE_OUT <= (nxt_power != POWER_SLEEP);
   end

   // ==========================================
   // Power switch high impedance
   // ==========================================
   // Disable pin wins regardless of command; lock faults elsewhere may then fire
   always_ff @(posedge MCLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         SWITCHES_HIZ_OUT <= 1'b1;
      else
         SWITCHES_HIZ_OUT <= OUTPUT_DISABLE_PIN_IN
                             || detect_fault_evt || retry_wait_ff
                             || nxt_power != POWER_RUN
                             || PARTIAL_SHUTDOWN_OUT || LATCHED_FAULT_IN;
   end

endmodule

// file: supervisor_sva.sv
// Property checker on the supervisor ports
`timescale 1ns/1ps
module supervisor_sva
   import supervisor_pkg::*;
(
   // Clock and reset
   input wire logic        MCLK_IN,
   input wire logic        RST_B_IN,
   // Watched inputs
   input wire logic        DETECT_TIMEOUT_FAULT_ENABLE_IN,
   input wire logic        PULSE_RATE_FAULT_ENABLE_IN,
   input wire logic        MEAS_BACKEMF_VALID_IN,
   input wire logic [15:0] MEAS_BACKEMF_IN,
   input wire logic [15:0] STATIONARY_DETECT_THRESHOLD_IN,
   input wire logic        SPEED_PIN_LOW_IN,
   input wire logic        OUTPUT_DISABLE_PIN_IN,
   input wire logic        LATCHED_FAULT_IN,
   input wire logic        CLEAR_FAULT_BIT_IN,
   // Watched outputs
   input wire fault_type   FAULTS_OUT,
   input wire power_type   POWER_STATE_OUT,
   input wire logic        SWITCHES_HIZ_OUT,
   input wire logic        SUPPLIES_ENABLE_OUT,
   input wire logic        STARTUP_ABORT_OUT,
   input wire logic        STARTUP_RETRY_OUT,
   input wire logic        PARTIAL_SHUTDOWN_OUT
);
   // Single clock domain
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RST_B_IN);

   // ==========================================
   // Switches and supplies
   // ==========================================
   property p_disable_hiz;
      OUTPUT_DISABLE_PIN_IN [*2] |-> SWITCHES_HIZ_OUT;
   endproperty
   a_disable_hiz: assert property (p_disable_hiz) else $error("disable ignored");
   property p_supplies;
      SUPPLIES_ENABLE_OUT == (POWER_STATE_OUT != POWER_SLEEP);
   endproperty
   a_supplies: assert property (p_supplies) else $error("supply enable wrong");
   property p_sleep_hiz;
      POWER_STATE_OUT == POWER_SLEEP && $past(POWER_STATE_OUT) == POWER_SLEEP |-> SWITCHES_HIZ_OUT;
   endproperty
   a_sleep_hiz: assert property (p_sleep_hiz) else $error("switches driven in sleep");
   // Sleep only after the pin stayed low
   sequence s_low_held;
      $past(SPEED_PIN_LOW_IN, 1) && $past(SPEED_PIN_LOW_IN, 8);
   endsequence
   sequence s_enter_sleep;
      $changed(POWER_STATE_OUT) && POWER_STATE_OUT == POWER_SLEEP;
   endsequence
   property p_sleep_entry;
      s_enter_sleep |-> s_low_held;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("early sleep");

   // ==========================================
   // Faults, abort and retry
   // ==========================================
   property p_sticky;
      !CLEAR_FAULT_BIT_IN |=> (FAULTS_OUT & $past(FAULTS_OUT)) == $past(FAULTS_OUT);
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault flag dropped");
   property p_rate_off;
      !PULSE_RATE_FAULT_ENABLE_IN && !FAULTS_OUT.pulse_rate_fault |=> !FAULTS_OUT.pulse_rate_fault;
   endproperty
   a_rate_off: assert property (p_rate_off) else $error("pulse-rate fault while disabled");
   property p_timeout_off;
      !DETECT_TIMEOUT_FAULT_ENABLE_IN && FAULTS_OUT[4:3] == 2'h0 |=> FAULTS_OUT[4:3] == 2'h0;
   endproperty
   a_timeout_off: assert property (p_timeout_off) else $error("timeout fault while disabled");
   property p_backemf;
      MEAS_BACKEMF_VALID_IN && MEAS_BACKEMF_IN < STATIONARY_DETECT_THRESHOLD_IN |=> FAULTS_OUT.meas_backemf_fault;
   endproperty
   a_backemf: assert property (p_backemf) else $error("low back-emf not flagged");
   property p_abort_hiz;
      STARTUP_ABORT_OUT |-> SWITCHES_HIZ_OUT;
   endproperty
   a_abort_hiz: assert property (p_abort_hiz) else $error("abort without hiz");
   property p_abort_cause;
      $rose(STARTUP_ABORT_OUT) |-> FAULTS_OUT[4:2] != 3'h0;
   endproperty
   a_abort_cause: assert property (p_abort_cause) else $error("abort without fault");
   property p_retry_pulse;
      STARTUP_RETRY_OUT |=> !STARTUP_RETRY_OUT;
   endproperty
   a_retry_pulse: assert property (p_retry_pulse) else $error("retry too long");
   property p_shutdown;
      LATCHED_FAULT_IN |=> PARTIAL_SHUTDOWN_OUT;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("no shutdown");
endmodule

// file: speed_ctrl_model.sv
// Model of the controller on the speed and disable pins
`timescale 1ns/1ps
module speed_ctrl_model
#(
   parameter int unsigned DISABLE_MIN_CYC = 16
)
(
   // Clock
   input  wire logic clk_in,
   // Pin levels seen by the supervisor
   output logic      pin_high_out,
   output logic      pin_low_out,
   output logic      disable_out
);
   // Pin rests between levels
   initial
   begin
      pin_high_out = 1'h0;
      pin_low_out  = 1'h0;
      disable_out  = 1'h0;
   end
   // One level for a detect window, then one idle cycle
   task automatic hold_pin(input logic high, input int unsigned cyc);
      pin_high_out = high;
      pin_low_out  = !high;
      repeat (cyc) @(posedge clk_in);
      #1;
      pin_high_out = 1'h0;
      pin_low_out  = 1'h0;
      @(posedge clk_in) #1;
   endtask
   // Short requests are stretched
   task automatic hold_disable(input int unsigned cyc);
      disable_out = 1'h1;
      repeat ((cyc < DISABLE_MIN_CYC) ? DISABLE_MIN_CYC : cyc) @(posedge clk_in);
      #1;
      disable_out = 1'h0;
   endtask
endmodule

// file: test_startup_supervisor.sv
// Self-checking testbench for the supervisor
`timescale 1ns/1ps
module test_startup_supervisor
   import supervisor_pkg::*;
;
   logic          clk, rst_b, tmo_en, rate_en, idle_sel, req, up_go, down_go, at_thr, cur_zero;
   logic          det_pulse, rl_act, bemf_vld, latched, cond, clr, pin_hi, pin_lo, drv_off;
   logic          hiz, sup, abort, retry, shut;
   logic [1:0]    method;
   logic [3:0]    retry_time;
   logic [15:0]   stat_thr, bemf, cmd;
   speed_cfg_type cfg;
   fault_type     faults;
   power_type     pstate;
   int            fail_count, check_count, cycles;

   speed_ctrl_model model (.clk_in(clk), .pin_high_out(pin_hi), .pin_low_out(pin_lo), .disable_out(drv_off));

   // Detect windows and retry unit shortened for simulation
   startup_supervisor #(.SLEEP_DET_CYC(20), .WAKE_DET_CYC(10), .RETRY_UNIT_CYC(50)) dut (
      .MCLK_IN(clk), .RST_B_IN(rst_b), .STARTUP_METHOD_IN(method),
      .DETECT_TIMEOUT_FAULT_ENABLE_IN(tmo_en), .PULSE_RATE_FAULT_ENABLE_IN(rate_en),
      .IDLE_STATE_SELECT_IN(idle_sel), .LOCK_RETRY_TIME_IN(retry_time), .SPEED_CFG_IN(cfg),
      .STATIONARY_DETECT_THRESHOLD_IN(stat_thr), .STARTUP_REQ_IN(req), .RAMPUP_START_IN(up_go),
      .RAMPDOWN_START_IN(down_go), .CURRENT_AT_THRESHOLD_IN(at_thr), .CURRENT_ZERO_IN(cur_zero),
      .DETECT_PULSE_IN(det_pulse), .MEAS_RL_ACTIVE_IN(rl_act), .MEAS_BACKEMF_VALID_IN(bemf_vld),
      .MEAS_BACKEMF_IN(bemf), .SPEED_COMMAND_IN(cmd), .SPEED_PIN_HIGH_IN(pin_hi),
      .SPEED_PIN_LOW_IN(pin_lo), .OUTPUT_DISABLE_PIN_IN(drv_off), .LATCHED_FAULT_IN(latched),
      .FAULT_CONDITION_ACTIVE_IN(cond), .CLEAR_FAULT_BIT_IN(clr), .FAULTS_OUT(faults),
      .POWER_STATE_OUT(pstate), .SWITCHES_HIZ_OUT(hiz), .SUPPLIES_ENABLE_OUT(sup),
      .STARTUP_ABORT_OUT(abort), .STARTUP_RETRY_OUT(retry), .PARTIAL_SHUTDOWN_OUT(shut));

   // ==========================================
   // Shared tasks
   // ==========================================
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded wait; caller judges
   task automatic wait_power(input power_type s);
      for (int i = 0; i < 64 && pstate !== s; i++) step();
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   // ==========================================
   task automatic t_pulse_rate();
      int n;
      method = STARTUP_POS_DET;
      retry_time = 4'h1;
      down_go = 1'h1; step(); down_go = 1'h0; step();
      det_pulse = 1'h1; step(); det_pulse = 0;
      check({faults, abort}, 6'h00);
      cur_zero = 1'h1; step(); cur_zero = 1'h0;
      rate_en = 1'h1;
      down_go = 1'h1; step(); down_go = 1'h0; step();
      det_pulse = 1'h1; step(); det_pulse = 1'h0;
      check({faults, abort, hiz}, 7'h13);
      for (n = 1; retry !== 1'h1 && n < 400; n++) step();
      check(n >= 99 && n <= 104, 16'h0001);
      step();
      check(abort, 16'h0000);
      clr = 1'h1; step(); clr = 1'h0;
      check(faults, 16'h0000);
      $display("pulse rate test done");
   endtask
   task automatic t_backemf();
      stat_thr = 16'h0100;
      bemf = 16'h00FF;
      bemf_vld = 1'h1; step(); bemf_vld = 1'h0;
      check(faults, 16'h0001);
      clr = 1'h1; step(); clr = 1'h0;
      bemf = 16'h0100;
      bemf_vld = 1'h1; step(); bemf_vld = 1'h0; step();
      check(faults, 16'h0000);
      $display("back-emf test done");
   endtask
   // Standby entry and exit per input mode
   task automatic t_standby();
      logic [1:0]  md [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
      logic [15:0] hy [7] = '{16'h0000, 16'h0100, 16'h1000, 16'h1000, 16'h1000, 16'h0000, 16'h0000};
      logic [15:0] mf [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0010, 16'h0010};
      logic [15:0] en [7] = '{16'h028F, 16'h028F, 16'h1000, 16'h07FF, 16'h0010, 16'h0003, 16'h0003};
      for (int i = 0; i < 7; i++)
      begin
         cfg = '{md[i], (i == 6) ? 2'h1 : 2'h0, hy[i], mf[i]};
         cmd = en[i];
         step(4);
         check(pstate, POWER_RUN);
         cmd = en[i] - 16'h0001;
         wait_power(POWER_STANDBY);
         check(pstate, POWER_STANDBY);
         cmd = (i == 0) ? PCT_5 : en[i];
         step(4);
         check({pstate, sup}, 3'h3);
         cmd = ((i == 0) ? PCT_5 : en[i]) + 16'h0001;
         wait_power(POWER_RUN);
         check(pstate, POWER_RUN);
      end
      $display("standby test done");
   endtask
   task automatic t_sleep();
      cmd = 16'hFFFF;
      idle_sel = 1'h1;
      model.hold_pin(1'h0, 10);
      step(3);
      check(pstate, POWER_RUN);
      model.hold_pin(1'h0, 25);
      check({pstate, sup, hiz}, 4'h9);
      model.hold_pin(1'h1, 5);
      check(pstate, POWER_SLEEP);
      model.hold_pin(1'h1, 14);
      wait_power(POWER_RUN);
      check({pstate, sup}, 3'h1);
      idle_sel = 1'h0;
      $display("sleep test done");
   endtask
   task automatic t_disable();
      fork
         model.hold_disable(4);
         begin
            step(3);
            check(hiz, 16'h0001);
            step(10);
            check(hiz, 16'h0001);
         end
      join
      $display("disable test done");
   endtask
   task automatic t_shutdown();
      latched = 1'h1; step(); latched = 1'h0;
      check(shut, 16'h0001);
      cond = 1'h1;
      clr = 1'h1; step(); clr = 1'h0; step();
      check(shut, 16'h0001);
      cond = 1'h0;
      clr = 1'h1; step(); clr = 1'h0; step();
      check(shut, 16'h0000);
      $display("shutdown test done");
   endtask

   // Free-running clock
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         close_out();
      end
   end
   // Main sequence
   initial
   begin
      {rst_b, tmo_en, rate_en, idle_sel, req, up_go, down_go, at_thr, cur_zero} = 9'h000;
      {det_pulse, rl_act, bemf_vld, latched, cond, clr} = 6'h00;
      method = 2'h0;
      retry_time = 4'h0;
      stat_thr = 16'h0000;
      bemf = 16'h0000;
      cmd = 16'hFFFF;
      cfg = '{SPEED_ANALOG, PROFILE_DEFAULT, 16'h0000, 16'h0000};
      step(2);
      check({faults, pstate, hiz, sup, abort, retry, shut}, 12'h018);
      step(3);
      rst_b = 1'h1;
      step(2);
      t_pulse_rate();
      t_backemf();
      t_standby();
      t_sleep();
      t_disable();
      t_shutdown();
      close_out();
   end
endmodule

bind startup_supervisor supervisor_sva chk (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN),
   .DETECT_TIMEOUT_FAULT_ENABLE_IN(DETECT_TIMEOUT_FAULT_ENABLE_IN),
   .PULSE_RATE_FAULT_ENABLE_IN(PULSE_RATE_FAULT_ENABLE_IN), .MEAS_BACKEMF_VALID_IN(MEAS_BACKEMF_VALID_IN),
   .MEAS_BACKEMF_IN(MEAS_BACKEMF_IN), .STATIONARY_DETECT_THRESHOLD_IN(STATIONARY_DETECT_THRESHOLD_IN),
   .SPEED_PIN_LOW_IN(SPEED_PIN_LOW_IN), .OUTPUT_DISABLE_PIN_IN(OUTPUT_DISABLE_PIN_IN),
   .LATCHED_FAULT_IN(LATCHED_FAULT_IN), .CLEAR_FAULT_BIT_IN(CLEAR_FAULT_BIT_IN), .FAULTS_OUT(FAULTS_OUT),
   .POWER_STATE_OUT(POWER_STATE_OUT), .SWITCHES_HIZ_OUT(SWITCHES_HIZ_OUT),
   .SUPPLIES_ENABLE_OUT(SUPPLIES_ENABLE_OUT), .STARTUP_ABORT_OUT(STARTUP_ABORT_OUT),
   .STARTUP_RETRY_OUT(STARTUP_RETRY_OUT), .PARTIAL_SHUTDOWN_OUT(PARTIAL_SHUTDOWN_OUT));
